// ===== hdl/bwd_tick.sv
// Microsecond enable divider
`timescale 1ns/1ps
`include "bwd_cfg.svh"
module bwd_tick (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Restart and tick
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [`BWD_DIV_W-1:0] cnt;
    logic tick;
  } bwd_tick_st_t;
  bwd_tick_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == `BWD_DIV_W'(`BWD_TICK_CYC - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + `BWD_DIV_W'(1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
  a_tick_spacing: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tick |=> !tick [*8]) else $error("tick too close");
endmodule : bwd_tick

// ===== hdl/bwd_watchdog.sv
// Board watchdog top with Wishbone slave
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "bwd_cfg.svh"
module bwd_watchdog (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Events
  output logic irq,
  output logic card_reset_req
);
  typedef struct packed {
    bwd_pkg::bwd_state_t st;
    logic en;
    logic rstmode;
    logic lock;
    logic [`BWD_CNT_W-1:0] preset;
    logic [`BWD_CNT_W-1:0] cnt;
    logic [1:0] stat;
    logic [1:0] ien;
    logic irq;
    logic [4:0] rcnt;
    logic rst_out;
    logic ack;
    logic [31:0] dat;
  } bwd_st_t;
  bwd_st_t s_q, s_d;
  // Log lives outside the cleared state so it survives card reset
  logic log_q, log_d;
  logic tick, restart;

  function automatic logic [`BWD_CNT_W-1:0] clamp(input logic [31:0] v);
    if (v[`BWD_CNT_W-1:0] < `BWD_PRESET_MIN || v[31:`BWD_CNT_W] != '0)
      clamp = (v[31:`BWD_CNT_W] != '0) ? `BWD_PRESET_MAX : `BWD_PRESET_MIN;
    else if (v[`BWD_CNT_W-1:0] > `BWD_PRESET_MAX)
      clamp = `BWD_PRESET_MAX;
    else
      clamp = v[`BWD_CNT_W-1:0];
  endfunction : clamp

  wire logic req = wb_cyc_i && wb_stb_i && !s_q.ack;
  wire logic wr = req && wb_we_i && wb_sel_i[0];
  wire logic [3:0] idx = wb_adr_i[5:2];
  wire logic expire = s_q.st == bwd_pkg::BWD_RUN && tick &&
    s_q.cnt == `BWD_CNT_W'(1);

  bwd_tick u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(restart),
    .tick(tick)
  );

  always_comb begin
    s_d = s_q;
    log_d = log_q;
    restart = 1'b0;
    s_d.ack = req;
    s_d.dat = 32'h0;
    if (req && !wb_we_i) begin
      case (idx)
        `BWD_ADR_CTRL: s_d.dat = {29'h0, s_q.lock, s_q.rstmode, s_q.en};
        `BWD_ADR_PRESET: s_d.dat = {8'h0, s_q.preset};
        `BWD_ADR_COUNT: s_d.dat = {8'h0, s_q.cnt};
        `BWD_ADR_STAT: s_d.dat = {30'h0, s_q.stat};
        `BWD_ADR_IEN: s_d.dat = {30'h0, s_q.ien};
        `BWD_ADR_LOG: s_d.dat = {31'h0, log_q};
        default: s_d.dat = 32'h0;
      endcase
    end
    // Countdown engine
    case (s_q.st)
      bwd_pkg::BWD_IDLE: begin
        if (s_q.en) begin
          s_d.cnt = s_q.preset;
          s_d.st = bwd_pkg::BWD_RUN;
          restart = 1'b1;
        end
      end
      bwd_pkg::BWD_RUN: begin
        if (!s_q.en) begin
          s_d.st = bwd_pkg::BWD_IDLE;
        end else if (expire) begin
          s_d.st = bwd_pkg::BWD_FIRED;
          s_d.cnt = '0;
          if (s_q.rstmode) begin
            s_d.rst_out = 1'b1;
            s_d.rcnt = 5'(`BWD_RST_PULSE_CYC);
            log_d = 1'b1;
          end else begin
            s_d.stat[0] = 1'b1;
          end
        end else if (tick) begin
          s_d.cnt = s_q.cnt - `BWD_CNT_W'(1);
        end
      end
      bwd_pkg::BWD_FIRED: begin
        if (!s_q.en) s_d.st = bwd_pkg::BWD_IDLE;
      end
      default: s_d.st = bwd_pkg::BWD_IDLE;
    endcase
    if (s_q.rcnt != '0) begin
      s_d.rcnt = s_q.rcnt - 5'(1);
      if (s_q.rcnt == 5'(1)) s_d.rst_out = 1'b0;
    end
    // Register writes
    if (wr) begin
      case (idx)
        `BWD_ADR_CTRL: begin
          if (!s_q.lock) begin
            s_d.en = wb_dat_i[`BWD_CTRL_EN];
            s_d.rstmode = wb_dat_i[`BWD_CTRL_RSTMODE];
            s_d.lock = wb_dat_i[`BWD_CTRL_EN] &&
              wb_dat_i[`BWD_CTRL_RSTMODE];
          end
          // Log clear loses to a reset-mode expiry in the same cycle
          if (wb_dat_i[`BWD_CTRL_LOGCLR] && !(expire && s_q.rstmode))
            log_d = 1'b0;
        end
        `BWD_ADR_PRESET: begin
          s_d.preset = clamp(wb_dat_i);
          // A service that meets expiry is too late: expiry wins
          if (s_q.en && s_q.st != bwd_pkg::BWD_FIRED && !expire) begin
            s_d.cnt = clamp(wb_dat_i);
            s_d.st = bwd_pkg::BWD_RUN;
            restart = 1'b1;
          end
        end
        `BWD_ADR_IEN: s_d.ien = wb_dat_i[1:0];
        `BWD_ADR_ICLR: begin
          // Set wins: only clear bits not being set now
          s_d.stat = s_q.stat & ~wb_dat_i[1:0] | (s_d.stat & ~s_q.stat);
        end
        default: ;
      endcase
    end
    // Stat bit 1: card-reset expiry event
    if (expire && s_q.rstmode) s_d.stat[1] = 1'b1;
    s_d.irq = |(s_d.stat & s_d.ien);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.st <= bwd_pkg::BWD_IDLE;
      s_q.preset <= `BWD_PRESET_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Log cleared only by software, not by card reset
  // Held while card reset is active, so bus noise cannot clear it
  always_ff @(posedge sys_clk) begin
    if (reset_n) begin
      log_q <= log_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign irq = s_q.irq;
  assign card_reset_req = s_q.rst_out;

  // Reset request must stay up long enough for the card to see it
  sequence s_reset_pulse;
    card_reset_req [*8];
  endsequence

  a_lock_holds: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_q.lock |=> s_q.lock && s_q.en) else $error("lock lost");
  a_lock_refuse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_q.lock && wr && idx == `BWD_ADR_CTRL |=> s_q.en && s_q.rstmode)
    else $error("locked control changed");
  a_irq_mode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    expire && !s_q.rstmode |=> s_q.stat[0] && !card_reset_req)
    else $error("irq mode");
  a_rst_mode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    expire && s_q.rstmode |=> card_reset_req && log_q)
    else $error("reset mode");
  a_cnt_step: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_q.st == bwd_pkg::BWD_RUN && s_q.en && tick && !expire && !wr
    |=> s_q.cnt == $past(s_q.cnt) - `BWD_CNT_W'(1)) else $error("step");
  a_preset_range: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_q.preset >= `BWD_PRESET_MIN && s_q.preset <= `BWD_PRESET_MAX)
    else $error("preset range");
  a_service_reload: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr && idx == `BWD_ADR_PRESET && s_q.en && !expire &&
    s_q.st == bwd_pkg::BWD_RUN
    |=> s_q.cnt == $past(clamp(wb_dat_i)) && s_q.st == bwd_pkg::BWD_RUN)
    else $error("reload");
  a_rst_pulse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(card_reset_req) |-> s_reset_pulse) else $error("pulse");
  a_log_survive: assert property (
    @(posedge sys_clk)
    !reset_n && log_q |=> log_q) else $error("log lost in reset");
  a_ack_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack twice");
endmodule : bwd_watchdog

// ===== shared/bwd_cfg.svh
// Watchdog constants: offsets, fields, reset values, timing
// Function
// - Counter loads a preset and counts down once per microsecond to expiry.
// - Timeout programmable from 1 us to 16 s in 1 us steps.
// - Software picks whether expiry raises an interrupt or resets the card.
// - Once enabled in reset mode, disabling is ignored until next card reset.
// - Log flag survives the watchdog card reset and shows its cause.
`ifndef BWD_CFG_SVH
`define BWD_CFG_SVH
`define BWD_ADR_CTRL 4'h0
`define BWD_ADR_PRESET 4'h1
`define BWD_ADR_COUNT 4'h2
`define BWD_ADR_STAT 4'h3
`define BWD_ADR_IEN 4'h4
`define BWD_ADR_ICLR 4'h5
`define BWD_ADR_LOG 4'h6
`define BWD_CTRL_EN 0
`define BWD_CTRL_RSTMODE 1
`define BWD_CTRL_LOGCLR 2
`define BWD_CNT_W 24
`define BWD_PRESET_MIN 24'h000001
`define BWD_PRESET_MAX 24'hf42400
`define BWD_PRESET_RST 24'hf42400
`define BWD_CLK_MHZ 25
`define BWD_TICK_US 1
`define BWD_TICK_CYC (`BWD_CLK_MHZ * `BWD_TICK_US)
`define BWD_DIV_W 5
`define BWD_RST_PULSE_CYC 16
`endif

// ===== shared/bwd_pkg.sv
// Watchdog types
package bwd_pkg;
  typedef enum logic [1:0] {
    BWD_IDLE,
    BWD_RUN,
    BWD_FIRED
  } bwd_state_t;
endpackage : bwd_pkg

// ===== verif/tb_top.sv
// Self-checking bench for the board watchdog
`timescale 1ns/1ps
`include "bwd_cfg.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  logic crr;
  logic found;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;
  always #20 sys_clk = ~sys_clk;
  bwd_watchdog DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .card_reset_req(crr)
  );
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the roughly 900 cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task run(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : run
  // Classic cycle: hold until ack is sampled high, then release
  task bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task wr(input logic [3:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task rdchk(input logic [3:0] i, input logic [31:0] exp);
    bus(1'b0, i, 32'h0);
    check(rd, exp);
  endtask : rdchk
  initial begin
    run(3);
    reset_n <= 1'b1;
    rdchk(`BWD_ADR_PRESET, {8'h00, `BWD_PRESET_RST});
    rdchk(`BWD_ADR_CTRL, 32'h0);
    wr(`BWD_ADR_CTRL, 32'h4);
    rdchk(`BWD_ADR_LOG, 32'h0);
    wr(`BWD_ADR_PRESET, 32'h0);
    rdchk(`BWD_ADR_PRESET, {8'h00, `BWD_PRESET_MIN});
    wr(`BWD_ADR_PRESET, 32'hffffff);
    rdchk(`BWD_ADR_PRESET, {8'h00, `BWD_PRESET_MAX});
    wr(4'hf, 32'h5);
    rdchk(4'hf, 32'h0);
    $display("test 1 done");
    // Interrupt mode, 5 us preset is 125 cycles
    wr(`BWD_ADR_IEN, 32'h1);
    wr(`BWD_ADR_PRESET, 32'h5);
    wr(`BWD_ADR_CTRL, 32'h1);
    rdchk(`BWD_ADR_COUNT, 32'h5);
    run(90);
    check({31'h0, irq}, 32'h0);
    run(80);
    check({31'h0, irq}, 32'h1);
    check({31'h0, crr}, 32'h0);
    rdchk(`BWD_ADR_STAT, 32'h1);
    wr(`BWD_ADR_IEN, 32'h0);
    run(2);
    check({31'h0, irq}, 32'h0);
    wr(`BWD_ADR_IEN, 32'h1);
    run(2);
    check({31'h0, irq}, 32'h1);
    wr(`BWD_ADR_ICLR, 32'h1);
    run(2);
    check({31'h0, irq}, 32'h0);
    $display("test 2 done");
    // Service every ~2 us against a 4 us preset
    wr(`BWD_ADR_CTRL, 32'h0);
    wr(`BWD_ADR_PRESET, 32'h4);
    wr(`BWD_ADR_CTRL, 32'h1);
    for (k = 0; k < 8; k++) begin
      run(40);
      wr(`BWD_ADR_PRESET, 32'h4);
    end
    check({31'h0, irq}, 32'h0);
    run(30);
    rdchk(`BWD_ADR_COUNT, 32'h3);
    run(150);
    check({31'h0, irq}, 32'h1);
    wr(`BWD_ADR_ICLR, 32'h1);
    wr(`BWD_ADR_CTRL, 32'h0);
    $display("test 3 done");
    // Reset mode: disable refused, expiry asks for card reset
    wr(`BWD_ADR_PRESET, 32'h3);
    wr(`BWD_ADR_CTRL, 32'h3);
    wr(`BWD_ADR_CTRL, 32'h0);
    rdchk(`BWD_ADR_CTRL, 32'h7);
    found = 1'b0;
    for (k = 0; k < 200 && !found; k++) begin
      @(posedge sys_clk);
      if (crr === 1'b1) found = 1'b1;
    end
    check({31'h0, found}, 32'h1);
    rdchk(`BWD_ADR_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    reset_n <= 1'b0;
    run(3);
    reset_n <= 1'b1;
    rdchk(`BWD_ADR_LOG, 32'h1);
    rdchk(`BWD_ADR_CTRL, 32'h0);
    wr(`BWD_ADR_CTRL, 32'h4);
    rdchk(`BWD_ADR_LOG, 32'h0);
    $display("test 4 done");
    report_and_stop();
  end
endmodule : tb_top
